// File: src/ars_pkg.sv
// Notes on behaviour
// - reserved register access raises illegal-operation fault
// - ignored register reads zero, writes discarded
// - unimplemented set members raise reserved-register fault
// - reserved fields always read back zero
// - non-zero reserved field write raises reserved fault
// - ignored fields read zero, writes discarded
// - undefined field encodings raise reserved fault on write
// - read-only write faults, register unchanged
// - 128 integer registers of 64 bits
// - 128 float registers, 96 rotating
// - 64 single-bit predicate registers
// - eight branch target registers
// - pointer holds bundle or legacy byte address
// - legacy integer state lives in integer 8..31
// - legacy float state lives in float 8..31
// - legacy mode blocked from native-only state
// - parallel float ops treat two singles independently
// - multimedia ops on 8, 16, 32-bit lanes
// - integer 0 reads zero, write faults
// - predicate 0 reads one, writes discarded
package ars_pkg;

  localparam int XLEN      = 64;
  localparam int FLEN      = 82;
  localparam int IDX_W     = 7;
  localparam int INT_COUNT = 128;
  localparam int FLT_COUNT = 128;
  localparam int PRD_COUNT = 64;
  localparam int BRN_COUNT = 8;

  // access classes; codes above CLS_APP are undefined register spaces
  localparam logic [2:0] CLS_INT = 3'h0;
  localparam logic [2:0] CLS_FLT = 3'h1;
  localparam logic [2:0] CLS_PRD = 3'h2;
  localparam logic [2:0] CLS_BRN = 3'h3;
  localparam logic [2:0] CLS_IPR = 3'h4;
  localparam logic [2:0] CLS_APP = 3'h5;

  localparam logic [1:0] OP_READ    = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_MM_ADD  = 2'h2;
  localparam logic [1:0] OP_PFP_NEG = 2'h3;

  localparam logic [1:0] ESZ_8  = 2'h0;
  localparam logic [1:0] ESZ_16 = 2'h1;
  localparam logic [1:0] ESZ_32 = 2'h2;

  // float rotation window
  localparam logic [6:0] FLT_ROT_BASE  = 7'h20;
  localparam logic [7:0] FLT_ROT_COUNT = 8'h60;
  localparam logic [6:0] FLT_ROT_LAST  = 7'h5f;

  // legacy window into integer and float files
  localparam logic [6:0] LEG_BASE  = 7'h08;
  localparam logic [6:0] LEG_COUNT = 7'h18;

  // application space map
  localparam logic [6:0] APP_SET_SLOTS = 7'h10;
  localparam logic [6:0] APP_SET_IMPL  = 7'h08;
  localparam logic [6:0] APP_CFG_IDX   = 7'h10;
  localparam logic [6:0] APP_RO_IDX    = 7'h11;
  localparam logic [6:0] APP_IGN_BASE  = 7'h20;

  // config register layout
  localparam int         CFG_MODE_LSB  = 0;
  localparam int         CFG_MODE_W    = 2;
  localparam logic [1:0] CFG_MODE_RSVD = 2'h3;
  localparam logic [1:0] CFG_MODE_RST  = 2'h0;
  localparam logic [63:0] CFG_RSVD_MASK = 64'hffff_ffff_ffff_00fc;

  localparam logic [63:0] IP_RST      = 64'h0000_0000_0000_0000;
  localparam logic [63:0] IP_BUNDLE   = 64'h0000_0000_0000_0010;
  localparam logic [63:0] IP_ALIGN    = 64'hffff_ffff_ffff_fff0;
  localparam logic [63:0] LEG_IP_MASK = 64'h0000_0000_ffff_ffff;

  localparam logic [81:0] FLT_ZERO = 82'h0;
  localparam logic [81:0] FLT_ONE  = 82'h0ffff_8000_0000_0000_0000;

  localparam int PFP_HI_SIGN = 63;
  localparam int PFP_LO_SIGN = 31;

endpackage

// File: src/ars_regfile.sv
`timescale 1ns/1ps
module ars_regfile (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        LEGACY_MODE,
  input  wire logic        REQ_VALID,
  input  wire logic [1:0]  REQ_OP,
  input  wire logic [2:0]  REQ_CLASS,
  input  wire logic [6:0]  REQ_INDEX,
  input  wire logic [1:0]  REQ_ESIZE,
  input  wire logic [81:0] REQ_WDATA,
  input  wire logic        STEP_VALID,
  input  wire logic [3:0]  STEP_LEN,
  input  wire logic        BRANCH_VALID,
  input  wire logic [63:0] BRANCH_TARGET,
  input  wire logic        ROT_STEP,
  input  wire logic        ROT_CLEAR,
  output logic             RESP_VALID,
  output logic [81:0]      RESP_RDATA,
  output logic             RESP_FAULT_ILLEGAL,
  output logic             RESP_FAULT_RSVD,
  output logic [63:0]      IP_VALUE
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [63:0] int_mem  [0:ars_pkg::INT_COUNT-1];
  logic [81:0] flt_mem  [0:ars_pkg::FLT_COUNT-1];
  logic [63:0] brn_mem  [0:ars_pkg::BRN_COUNT-1];
  logic [63:0] app_mem  [0:7];
  logic [63:0] prd_ff;
  logic [63:0] ip_ff;
  logic [6:0]  rrb_ff;
  logic [1:0]  cfg_mode_ff;
  logic [63:0] wr_count_ff;
  logic        resp_valid_ff;
  logic [81:0] resp_rdata_ff;
  logic        fault_ill_ff;
  logic        fault_rsvd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  wire is_int = (REQ_CLASS == ars_pkg::CLS_INT);
  wire is_flt = (REQ_CLASS == ars_pkg::CLS_FLT);
  wire is_prd = (REQ_CLASS == ars_pkg::CLS_PRD);
  wire is_brn = (REQ_CLASS == ars_pkg::CLS_BRN);
  wire is_ipr = (REQ_CLASS == ars_pkg::CLS_IPR);
  wire is_app = (REQ_CLASS == ars_pkg::CLS_APP);
  wire cls_undef = (REQ_CLASS > ars_pkg::CLS_APP);
  wire op_rd  = (REQ_OP == ars_pkg::OP_READ);
  wire op_mm  = (REQ_OP == ars_pkg::OP_MM_ADD);
  wire op_pfp = (REQ_OP == ars_pkg::OP_PFP_NEG);
  wire op_wr  = !op_rd;

  // legacy numbering: register n of the legacy set sits at LEG_BASE + n
  wire       leg_idx_ok = (REQ_INDEX < ars_pkg::LEG_COUNT);
  wire [6:0] leg_idx    = REQ_INDEX + ars_pkg::LEG_BASE;
  wire       leg_block  = LEGACY_MODE &&
                          (!(is_int || is_flt) || !leg_idx_ok);
  wire [6:0] arch_idx   = LEGACY_MODE ? leg_idx : REQ_INDEX;

  // rotating float registers are renamed through the rename base
  wire [6:0] rot_off  = arch_idx - ars_pkg::FLT_ROT_BASE;
  wire [7:0] rot_sum  = {1'b0, rot_off} + {1'b0, rrb_ff};
  wire [7:0] rot_wrap = (rot_sum >= ars_pkg::FLT_ROT_COUNT) ?
                        rot_sum - ars_pkg::FLT_ROT_COUNT : rot_sum;
  wire [7:0] rot_phys = rot_wrap + {1'b0, ars_pkg::FLT_ROT_BASE};
  wire       flt_rot  = (arch_idx >= ars_pkg::FLT_ROT_BASE);
  wire [6:0] flt_idx  = flt_rot ? rot_phys[6:0] : arch_idx;

  ////////////////////////////////////////////////////////////////////////////
  // legality

  // compute ops only exist for their own files
  wire op_mismatch = (op_mm && !is_int) || (op_pfp && !is_flt);
  wire esz_rsvd    = op_mm && (REQ_ESIZE > ars_pkg::ESZ_32);

  wire int_ill = is_int && op_wr && (arch_idx == 7'h00);
  // the two constant float registers refuse to be destinations
  wire flt_ill = is_flt && op_wr && (arch_idx < 7'h02);
  wire prd_ill = is_prd && (REQ_INDEX >= 7'(ars_pkg::PRD_COUNT));
  wire brn_ill = is_brn && (REQ_INDEX >= 7'(ars_pkg::BRN_COUNT));
  wire ipr_ill = is_ipr && ((REQ_INDEX != 7'h00) || op_wr);

  wire app_set  = is_app && (REQ_INDEX < ars_pkg::APP_SET_SLOTS);
  wire app_impl = app_set && (REQ_INDEX < ars_pkg::APP_SET_IMPL);
  wire app_unim = app_set && !app_impl;
  wire app_cfg  = is_app && (REQ_INDEX == ars_pkg::APP_CFG_IDX);
  wire app_ro   = is_app && (REQ_INDEX == ars_pkg::APP_RO_IDX);
  wire app_ign  = is_app && (REQ_INDEX >= ars_pkg::APP_IGN_BASE);
  wire app_rsvd = is_app && !app_set && !app_cfg && !app_ro &&
                  !app_ign;
  wire app_ill  = app_rsvd || (app_ro && op_wr);

  wire [1:0] cfg_wmode = REQ_WDATA[ars_pkg::CFG_MODE_LSB +:
                                   ars_pkg::CFG_MODE_W];
  wire cfg_bits_bad = |(REQ_WDATA[63:0] & ars_pkg::CFG_RSVD_MASK);
  wire cfg_enc_bad  = (cfg_wmode == ars_pkg::CFG_MODE_RSVD);
  wire cfg_rsvd     = app_cfg && op_wr && (cfg_bits_bad || cfg_enc_bad);

  wire fault_ill  = cls_undef || leg_block || op_mismatch || int_ill ||
                    flt_ill || prd_ill || brn_ill || ipr_ill ||
                    app_ill;
  wire fault_rsvd = !fault_ill &&
                    (app_unim || cfg_rsvd || esz_rsvd);
  wire any_fault  = fault_ill || fault_rsvd;
  wire commit     = REQ_VALID && op_wr && !any_fault;

  ////////////////////////////////////////////////////////////////////////////
  // lane arithmetic

  function automatic logic [63:0] mm_add(input logic [63:0] a,
                                         input logic [63:0] b,
                                         input logic [1:0]  sz);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 8; i++) begin
      if (sz == ars_pkg::ESZ_8) begin
        r[i*8 +: 8] = a[i*8 +: 8] + b[i*8 +: 8];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (sz == ars_pkg::ESZ_16) begin
        r[i*16 +: 16] = a[i*16 +: 16] + b[i*16 +: 16];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (sz == ars_pkg::ESZ_32) begin
        r[i*32 +: 32] = a[i*32 +: 32] + b[i*32 +: 32];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // read data

  wire [63:0] int_raw = int_mem[arch_idx];
  wire [63:0] int_rd  = (arch_idx == 7'h00) ? 64'h0 : int_raw;
  wire [81:0] flt_raw = flt_mem[flt_idx];
  wire [81:0] flt_rd  = (arch_idx == 7'h00) ? ars_pkg::FLT_ZERO :
                        (arch_idx == 7'h01) ? ars_pkg::FLT_ONE : flt_raw;
  wire [5:0]  prd_sel = REQ_INDEX[5:0];
  wire        prd_rd  = (prd_sel == 6'h00) ? 1'b1 : prd_ff[prd_sel];
  wire [63:0] brn_rd  = brn_mem[REQ_INDEX[2:0]];
  wire [63:0] app_set_rd = app_mem[REQ_INDEX[2:0]];
  // reserved and ignored config bits read back as zero
  wire [63:0] cfg_rd  = {62'h0, cfg_mode_ff};
  wire [63:0] app_rd  = app_impl ? app_set_rd :
                        app_cfg  ? cfg_rd :
                        app_ro   ? wr_count_ff : 64'h0;

  wire [81:0] rd_data = is_int ? {18'h0, int_rd} :
                        is_flt ? flt_rd :
                        is_prd ? {81'h0, prd_rd} :
                        is_brn ? {18'h0, brn_rd} :
                        is_ipr ? {18'h0, ip_ff} :
                        is_app ? {18'h0, app_rd} : 82'h0;

  ////////////////////////////////////////////////////////////////////////////
  // write data

  wire [63:0] int_wval = op_mm ? mm_add(int_rd, REQ_WDATA[63:0], REQ_ESIZE)
                               : REQ_WDATA[63:0];
  // each single keeps its own sign; the halves never interact
  wire [81:0] pfp_flip = {18'h0,
                          REQ_WDATA[1], 31'h0, REQ_WDATA[0], 31'h0};
  wire [81:0] flt_wval = op_pfp ? (flt_raw ^ pfp_flip)
                                : REQ_WDATA;

  wire int_we = commit && is_int;
  wire flt_we = commit && is_flt;
  // a predicate 0 target silently drops its result
  wire prd_we = commit && is_prd && (prd_sel != 6'h00);
  wire brn_we = commit && is_brn;
  wire app_we = commit && app_impl;
  wire cfg_we = commit && app_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // instruction pointer

  wire [63:0] ip_step_nat = (ip_ff & ars_pkg::IP_ALIGN) + ars_pkg::IP_BUNDLE;
  wire [63:0] ip_step_leg = (ip_ff + {60'h0, STEP_LEN}) & ars_pkg::LEG_IP_MASK;
  wire [63:0] br_nat      = BRANCH_TARGET & ars_pkg::IP_ALIGN;
  wire [63:0] br_leg      = BRANCH_TARGET & ars_pkg::LEG_IP_MASK;
  wire [63:0] nxt_ip_ff   = BRANCH_VALID ? (LEGACY_MODE ? br_leg : br_nat) :
                            STEP_VALID   ? (LEGACY_MODE ? ip_step_leg :
                                            ip_step_nat) : ip_ff;

  wire [6:0] nxt_rrb_ff = ROT_CLEAR ? 7'h00 :
                          !ROT_STEP ? rrb_ff :
                          (rrb_ff == 7'h00) ? ars_pkg::FLT_ROT_LAST :
                          rrb_ff - 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge SYS_CLK) begin
    if (int_we) begin
      int_mem[arch_idx] <= int_wval;
    end
    if (flt_we) begin
      flt_mem[flt_idx] <= flt_wval;
    end
    if (brn_we) begin
      brn_mem[REQ_INDEX[2:0]] <= REQ_WDATA[63:0];
    end
    if (app_we) begin
      app_mem[REQ_INDEX[2:0]] <= REQ_WDATA[63:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prd_ff      <= 64'h0;
      ip_ff       <= ars_pkg::IP_RST;
      rrb_ff      <= 7'h00;
      cfg_mode_ff <= ars_pkg::CFG_MODE_RST;
      wr_count_ff <= 64'h0;
    end else begin
      if (prd_we) begin
        prd_ff[prd_sel] <= REQ_WDATA[0];
      end
      ip_ff  <= nxt_ip_ff;
      rrb_ff <= nxt_rrb_ff;
      if (cfg_we) begin
        cfg_mode_ff <= cfg_wmode;
      end
      if (commit) begin
        wr_count_ff <= wr_count_ff + 64'h1;
      end
    end
  end

  // answer one cycle after the request; faulting reads return zero
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      resp_valid_ff <= 1'b0;
      resp_rdata_ff <= 82'h0;
      fault_ill_ff  <= 1'b0;
      fault_rsvd_ff <= 1'b0;
    end else begin
      resp_valid_ff <= REQ_VALID;
      resp_rdata_ff <= (REQ_VALID && op_rd && !any_fault) ? rd_data : 82'h0;
      fault_ill_ff  <= REQ_VALID && fault_ill;
      fault_rsvd_ff <= REQ_VALID && fault_rsvd;
    end
  end

  assign RESP_VALID         = resp_valid_ff;
  assign RESP_RDATA         = resp_rdata_ff;
  assign RESP_FAULT_ILLEGAL = fault_ill_ff;
  assign RESP_FAULT_RSVD    = fault_rsvd_ff;
  assign IP_VALUE           = ip_ff;

endmodule

// File: tb/ars_regfile_checker.sv
`timescale 1ns/1ps
module ars_regfile_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        LEGACY_MODE,
  input wire logic        REQ_VALID,
  input wire logic [1:0]  REQ_OP,
  input wire logic [2:0]  REQ_CLASS,
  input wire logic [6:0]  REQ_INDEX,
  input wire logic [81:0] REQ_WDATA,
  input wire logic        BRANCH_VALID,
  input wire logic [63:0] BRANCH_TARGET,
  input wire logic        RESP_VALID,
  input wire logic [81:0] RESP_RDATA,
  input wire logic        RESP_FAULT_ILLEGAL,
  input wire logic        RESP_FAULT_RSVD,
  input wire logic [63:0] IP_VALUE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // native read or write into the application space
  wire app = REQ_VALID && !LEGACY_MODE && REQ_CLASS == 3'h5 && !REQ_OP[1];
  wire cfg_w = app && REQ_OP[0] && REQ_INDEX == 7'h10;
  wire nat = REQ_VALID && !LEGACY_MODE;
  ////////////////////////////////////////////////////////////////////////////
  a_bad_class: assert property (REQ_VALID && REQ_CLASS > 3'h5
    |=> RESP_FAULT_ILLEGAL) else $error("undefined class accepted");
  a_ignored_zero: assert property (app && REQ_INDEX >= 7'h20
    |=> RESP_VALID && RESP_RDATA == 82'h0 && !RESP_FAULT_ILLEGAL
      && !RESP_FAULT_RSVD) else $error("ignored register misbehaved");
  a_unimpl_rsvd: assert property (app && REQ_INDEX[6:3] == 4'h1
    |=> RESP_FAULT_RSVD) else $error("unimplemented slot accepted");
  a_cfg_rsvd_bits: assert property (cfg_w
    && (REQ_WDATA[63:0] & ars_pkg::CFG_RSVD_MASK) != 64'h0
    |=> RESP_FAULT_RSVD) else $error("reserved bits accepted");
  a_cfg_bad_mode: assert property (cfg_w && REQ_WDATA[1:0] == 2'h3
    |=> RESP_FAULT_RSVD) else $error("reserved mode accepted");
  a_ro_write: assert property (app && REQ_OP[0] && REQ_INDEX == 7'h11
    |=> RESP_FAULT_ILLEGAL) else $error("read-only write accepted");
  a_int0_write: assert property (nat && REQ_CLASS == 3'h0
    && REQ_OP != 2'h0 && REQ_INDEX == 7'h0 |=> RESP_FAULT_ILLEGAL)
    else $error("integer zero written");
  a_pred0_one: assert property (nat && REQ_CLASS == 3'h2
    && REQ_OP == 2'h0 && REQ_INDEX == 7'h0 |=> RESP_RDATA == 82'h1)
    else $error("predicate zero not one");
  a_legacy_block: assert property (REQ_VALID && LEGACY_MODE
    && REQ_CLASS > 3'h1 |=> RESP_FAULT_ILLEGAL)
    else $error("legacy reached native state");
  a_branch_align: assert property (BRANCH_VALID && !LEGACY_MODE
    |=> IP_VALUE == ($past(BRANCH_TARGET) & ars_pkg::IP_ALIGN))
    else $error("branch target not aligned");
  a_fault_clean: assert property (RESP_FAULT_ILLEGAL || RESP_FAULT_RSVD
    |-> RESP_VALID && RESP_RDATA == 82'h0
      && !(RESP_FAULT_ILLEGAL && RESP_FAULT_RSVD))
    else $error("fault response not clean");
endmodule
bind ars_regfile ars_regfile_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .LEGACY_MODE(LEGACY_MODE), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
  .REQ_CLASS(REQ_CLASS), .REQ_INDEX(REQ_INDEX), .REQ_WDATA(REQ_WDATA),
  .BRANCH_VALID(BRANCH_VALID), .BRANCH_TARGET(BRANCH_TARGET),
  .RESP_VALID(RESP_VALID), .RESP_RDATA(RESP_RDATA), .IP_VALUE(IP_VALUE),
  .RESP_FAULT_ILLEGAL(RESP_FAULT_ILLEGAL), .RESP_FAULT_RSVD(RESP_FAULT_RSVD));

// File: tb/ars_regfile_tb.sv
`timescale 1ns/1ps
module ars_regfile_tb;
  localparam logic [1:0] OK = 2'h0, RV = 2'h1, IL = 2'h2;
  logic        SYS_CLK = 1'b0, RST = 1'b1, LEGACY_MODE = 1'b0;
  logic        REQ_VALID = 1'b0, STEP_VALID = 1'b0, BRANCH_VALID = 1'b0;
  logic        ROT_STEP = 1'b0, ROT_CLEAR = 1'b0;
  logic [1:0]  REQ_OP = 2'h0, REQ_ESIZE = 2'h0;
  logic [2:0]  REQ_CLASS = 3'h0;
  logic [6:0]  REQ_INDEX = 7'h0;
  logic [3:0]  STEP_LEN = 4'h0;
  logic [81:0] REQ_WDATA = 82'h0, RESP_RDATA;
  logic [63:0] BRANCH_TARGET = 64'h0, IP_VALUE, v, w, s;
  logic        RESP_VALID, RESP_FAULT_ILLEGAL, RESP_FAULT_RSVD;
  logic [83:0] expq[$];
  int          mismatches = 0, total_checks = 0;
  integer      seed = 32'h5214329d;

  ars_regfile u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .LEGACY_MODE(LEGACY_MODE),
    .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_CLASS(REQ_CLASS),
    .REQ_INDEX(REQ_INDEX), .REQ_ESIZE(REQ_ESIZE), .REQ_WDATA(REQ_WDATA),
    .STEP_VALID(STEP_VALID), .STEP_LEN(STEP_LEN), .IP_VALUE(IP_VALUE),
    .BRANCH_VALID(BRANCH_VALID), .BRANCH_TARGET(BRANCH_TARGET),
    .ROT_STEP(ROT_STEP), .ROT_CLEAR(ROT_CLEAR), .RESP_VALID(RESP_VALID),
    .RESP_RDATA(RESP_RDATA), .RESP_FAULT_ILLEGAL(RESP_FAULT_ILLEGAL),
    .RESP_FAULT_RSVD(RESP_FAULT_RSVD));

  initial begin
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    mismatches++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_resp(input logic [83:0] e);
    total_checks++;
    if ({RESP_FAULT_ILLEGAL, RESP_FAULT_RSVD, RESP_RDATA} !== e)
      fail("response mismatch");
  endtask
  task automatic chk_ip(input logic [63:0] e);
    total_checks++;
    if (IP_VALUE !== e) fail("pointer mismatch");
  endtask
  task automatic tick(input logic st, br, rs, rc);
    @(posedge SYS_CLK);
    #1;
    REQ_VALID = 1'b0;
    {STEP_VALID, BRANCH_VALID, ROT_STEP, ROT_CLEAR} = {st, br, rs, rc};
  endtask
  // one request per cycle, expectation noted as it is launched
  task automatic req(input logic [1:0] op, input logic [2:0] c,
      input logic [6:0] i, input logic [1:0] z, input logic [81:0] d, e,
      input logic [1:0] f);
    @(posedge SYS_CLK);
    #1;
    {STEP_VALID, BRANCH_VALID, ROT_STEP, ROT_CLEAR} = 4'h0;
    {REQ_VALID, REQ_OP, REQ_CLASS, REQ_INDEX, REQ_ESIZE} = {1'b1, op, c, i, z};
    REQ_WDATA = d;
    expq.push_back({f, e});
  endtask
  function automatic logic [63:0] ladd(input logic [63:0] a, b, input int n);
    logic        c;
    logic [63:0] r;
    for (int i = 0; i < 64; i++) begin
      if (i % n == 0) c = 1'b0;
      r[i] = a[i] ^ b[i] ^ c;
      c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
    end
    return r;
  endfunction

  always @(posedge SYS_CLK) begin
    #2;
    if (RESP_VALID === 1'b1 && expq.size() == 0) fail("stray response");
    else if (RESP_VALID === 1'b1) chk_resp(expq.pop_front());
  end
  // generous: the whole sequence needs about seventy cycles
  initial begin
    #3000;
    fail("timeout");
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    v = {$random(seed), $random(seed)};
    w = {$random(seed), $random(seed)};
    repeat (3) @(posedge SYS_CLK);
    #1 RST = 1'b0;
    req(1, 0, 127, 0, v, 0, OK);
    req(0, 0, 127, 0, 0, v, OK);
    req(1, 0, 0, 0, v, 0, IL);
    req(0, 0, 0, 0, 0, 0, OK);
    req(1, 0, 5, 0, v, 0, OK);
    for (int k = 0; k < 3; k++) req(2, 0, 5, 2'(k), w, 0, OK);
    s = ladd(ladd(ladd(v, w, 8), w, 16), w, 32);
    req(2, 0, 5, 3, w, 0, RV);
    req(0, 0, 5, 0, 0, s, OK);
    $display("test integer done");
    req(1, 1, 1, 0, v, 0, IL);
    req(0, 1, 1, 0, 0, ars_pkg::FLT_ONE, OK);
    req(0, 1, 0, 0, 0, ars_pkg::FLT_ZERO, OK);
    req(1, 1, 40, 0, v, 0, OK);
    // both sign bits flip, each from its own strobe bit
    req(3, 1, 40, 0, 3, 0, OK);
    req(0, 1, 40, 0, 0, v ^ 64'h8000_0000_8000_0000, OK);
    tick(1'b0, 1'b0, 1'b1, 1'b0);
    req(0, 1, 41, 0, 0, v ^ 64'h8000_0000_8000_0000, OK);
    tick(1'b0, 1'b0, 1'b1, 1'b1);
    req(0, 1, 40, 0, 0, v ^ 64'h8000_0000_8000_0000, OK);
    $display("test float done");
    req(1, 2, 63, 0, 1, 0, OK);
    req(0, 2, 63, 0, 0, 1, OK);
    req(1, 2, 0, 0, 0, 0, OK);
    req(0, 2, 0, 0, 0, 1, OK);
    req(0, 2, 64, 0, 0, 0, IL);
    req(1, 3, 7, 0, w, 0, OK);
    req(0, 3, 7, 0, 0, w, OK);
    req(0, 3, 8, 0, 0, 0, IL);
    $display("test predicate branch done");
    req(1, 5, 40, 0, v, 0, OK);
    req(0, 5, 40, 0, 0, 0, OK);
    for (int k = 8; k < 16; k++) req(0, 5, 7'(k), 0, 0, 0, RV);
    req(0, 5, 20, 0, 0, 0, IL);
    req(0, 6, 0, 0, 0, 0, IL);
    req(1, 7, 0, 0, v, 0, IL);
    req(1, 5, 16, 0, 64'hff02, 0, OK);
    req(1, 5, 16, 0, 64'h1_0001, 0, RV);
    req(1, 5, 16, 0, 64'h3, 0, RV);
    req(0, 5, 16, 0, 0, 64'h2, OK);
    req(1, 5, 16, 0, 64'h2, 0, OK);
    req(1, 5, 17, 0, v, 0, IL);
    req(1, 5, 3, 0, w, 0, OK);
    req(0, 5, 3, 0, 0, w, OK);
    // fourteen clean writes so far, faulting ones never counted
    req(0, 5, 17, 0, 0, 64'he, OK);
    $display("test application done");
    tick(1'b0, 1'b0, 1'b0, 1'b0);
    LEGACY_MODE = 1'b1;
    req(1, 0, 0, 0, v, 0, OK);
    req(1, 1, 1, 0, w, 0, OK);
    req(0, 2, 0, 0, 0, 0, IL);
    req(0, 0, 24, 0, 0, 0, IL);
    BRANCH_TARGET = v;
    STEP_LEN = 4'h3;
    tick(1'b0, 1'b1, 1'b0, 1'b0);
    tick(1'b1, 1'b0, 1'b0, 1'b0);
    chk_ip(v & ars_pkg::LEG_IP_MASK);
    tick(1'b0, 1'b0, 1'b0, 1'b0);
    chk_ip({32'h0, v[31:0] + 32'h3});
    LEGACY_MODE = 1'b0;
    req(0, 0, 8, 0, 0, v, OK);
    req(0, 1, 9, 0, 0, w, OK);
    BRANCH_TARGET = w;
    tick(1'b0, 1'b1, 1'b0, 1'b0);
    tick(1'b1, 1'b0, 1'b0, 1'b0);
    chk_ip(w & ars_pkg::IP_ALIGN);
    s = (w & ars_pkg::IP_ALIGN) + 64'h10;
    req(0, 4, 0, 0, 0, s, OK);
    req(1, 4, 0, 0, v, 0, IL);
    $display("test pointer done");
    tick(1'b0, 1'b0, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0, 1'b0);
    if (expq.size() != 0) fail("missing response");
    summarize();
  end
endmodule
